// ---- bench/i2cc_channel_setup_tb.sv ----
// Self-checking bench for the I2C channel setup block
`timescale 1ns/1ns
module i2cc_channel_setup_tb
	import i2cc_pkg::*;
;
	logic clk_sys_in = 1'b0;
	logic clk_link = 1'b0;
	logic rst_n_in = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, scl_oe, sda_oe, scl_o, sda_o, rel, fwd0, fwd1;
	logic [6:0] tid;
	logic stretch, valid;
	logic slave_go = 1'b0;
	logic sbit = 1'b1;
	logic rel_seen = 1'b0;
	logic pick_sda = 1'b0;
	logic go = 1'b0;
	logic glitch = 1'b0;
	logic [6:0] id = 7'h00;
	logic p_scl, p_sda, done, scl_w, sda_w, watch;
	int mismatches = 0;
	int tests_run = 0;
	// Open-drain wires: anyone pulling low wins
	assign scl_w = p_scl & ~(scl_oe & ~scl_o);
	assign sda_w = p_sda & ~(sda_oe & ~sda_o);
	assign watch = pick_sda ? sda_oe : scl_oe;
	// Unrelated phases for the two clocks
	always #5 clk_sys_in = ~clk_sys_in;
	initial
	begin
		#7;
		forever #16 clk_link = ~clk_link;
	end
	// Latch the release; the slave request drops with it
	assign stretch = slave_go & ~rel_seen;
	assign valid = stretch;
	always @(posedge clk_link)
		if (rel === 1'b1)
			rel_seen <= 1'b1;
	i2cc_channel_setup i2cc_channel_setup_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.clk_link_in(clk_link), .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe),
		.sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe), .slave_stretch_in(stretch),
		.slave_data_valid_in(valid), .slave_sda_bit_in(sbit), .slave_release_out(rel),
		.fwd_port0_out(fwd0), .fwd_port1_out(fwd1), .target_id_out(tid));
	i2cc_i2c_partner i2cc_i2c_partner_inst (.clk_link_in(clk_link), .go_in(go),
		.glitch_in(glitch), .id_in(id), .scl_out(p_scl), .sda_out(p_sda), .done_out(done));
	// ----
	// Reporting
	// ----
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x)
		begin
			mismatches++;
			$display("FAIL at %0t ns: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic hung();
		chk(32'h0, 32'h1);
		results();
	endtask
	// ----
	// APB master; pready is always awaited, never assumed
	// ----
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {a, 2'b00};
		pwdata <= d;
		@(posedge clk_sys_in);
		penable <= 1'b1;
		@(posedge clk_sys_in);
		while (pready !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge clk_sys_in);
		end
		if (n == 20)
			hung();
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, x);
	endtask
	// One address frame from the far side, checked while it stands
	task automatic frame(input logic [6:0] i, input logic g, input logic x0, input logic x1);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		id <= i;
		glitch <= g;
		go <= 1'b1;
		while (done !== 1'b1 && n < 5000)
		begin
			n++;
			@(posedge clk_sys_in);
		end
		if (n == 5000)
			hung();
		chk({31'h0, fwd0}, {31'h0, x0});
		chk({31'h0, fwd1}, {31'h0, x1});
		chk({25'h0, tid}, {25'h0, i});
		go <= 1'b0;
		while (done !== 1'b0 && n < 9000)
		begin
			n++;
			@(posedge clk_sys_in);
		end
		if (n == 9000)
			hung();
	endtask
	// Length of the next run of the watched enable at level v, in link cycles
	task automatic span(input logic v, output int n);
		int k;
		k = 0;
		n = 0;
		while (watch !== v && k < 2000)
		begin
			k++;
			@(posedge clk_link);
		end
		if (k == 2000)
			hung();
		while (watch === v && n < 2000)
		begin
			n++;
			@(posedge clk_link);
		end
		if (n == 2000)
			hung();
	endtask
	// ----
	// Main sequence
	// ----
	logic [7:0] row_idx [5] = '{8'h17, 8'h18, 8'h19, 8'h22, 8'h30};
	logic [31:0] row_wd [5] = '{32'h5A, 32'hFFFFFF01, 32'h80, 32'hFF, 32'h55};
	logic [31:0] row_rd [5] = '{32'h5A, 32'h01, 32'h80, 32'h00, 32'h00};
	logic row_err [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	initial
	begin
		logic [31:0] q;
		logic e;
		int n;
		repeat (8) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		// Write then read back; upper bits, read-only status and a hole
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, row_idx[i], row_wd[i], q, e);
			chk({31'h0, e}, {31'h0, row_err[i]});
			apb(1'b0, row_idx[i], 32'h0, q, e);
			chk(q, row_rd[i]);
			chk({31'h0, e}, {31'h0, row_err[i]});
		end
		$display("test register rows done");
		// Reset in mid-run restores the timing defaults
		rst_n_in <= 1'b0;
		repeat (8) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		rd(8'h17, 32'h1E);
		rd(8'h18, 32'h7F);
		rd(8'h19, 32'h7F);
		$display("test reset values done");
		// Forwarding decision; two frames carry a rejected spike on every bit
		frame(7'h2C, 1'b1, 1'b1, 1'b1);
		frame(7'h50, 1'b0, 1'b1, 1'b1);
		frame(7'h33, 1'b1, 1'b0, 1'b0);
		wr(8'h17, 32'h9E);
		frame(7'h33, 1'b0, 1'b1, 1'b0);
		frame(7'h0C, 1'b0, 1'b0, 1'b0);
		wr(8'h20, 32'h1);
		rd(8'h17, 32'h1E);
		wr(8'h17, 32'h9E);
		wr(8'h20, 32'h0);
		wr(8'h17, 32'h1E);
		rd(8'h17, 32'h1E);
		frame(7'h33, 1'b0, 1'b0, 1'b1);
		$display("test forwarding done");
		// Master clock phases with short counts
		wr(8'h19, 32'h02);
		wr(8'h18, 32'h03);
		wr(8'h20, 32'h2);
		span(1'b0, n);
		span(1'b1, n);
		chk(n, 7);
		span(1'b0, n);
		chk(n, 8);
		wr(8'h20, 32'h0);
		$display("test master timing done");
		// Slave data setup before the stretched clock is let go
		pick_sda <= 1'b1;
		@(posedge clk_link);
		sbit <= 1'b0;
		slave_go <= 1'b1;
		span(1'b1, n);
		chk(n, 7);
		chk({31'h0, rel_seen}, 32'h1);
		chk({31'h0, sda_o}, 32'h0);
		$display("test slave setup done");
		results();
	end
endmodule

// ---- bench/i2cc_i2c_partner.sv ----
// Local I2C master on the far side of the block, sending START, one address byte, STOP
`timescale 1ns/1ns
module i2cc_i2c_partner
(
	input wire logic clk_link_in,
	input wire logic go_in,
	input wire logic glitch_in,
	input wire logic [6:0] id_in,
	output logic scl_out,
	output logic sda_out,
	output logic done_out
);
	// Ten link cycles per quarter bit keeps well clear of filter and hold
	task automatic half();
		repeat (10) @(posedge clk_link_in);
	endtask
	// ----
	// Frame sequencer; lines idle high through the pull-ups
	// ----
	initial
	begin
		logic [7:0] frame;
		scl_out = 1'b1;
		sda_out = 1'b1;
		done_out = 1'b0;
		forever
		begin
			@(posedge clk_link_in);
			if (go_in && !done_out)
			begin
				frame = {id_in, 1'b0};
				sda_out <= 1'b0;
				half();
				for (int i = 7; i >= 0; i--)
				begin
					scl_out <= 1'b0;
					half();
					sda_out <= frame[i];
					half();
					scl_out <= 1'b1;
					half();
					// One-cycle low spike that the filter has to swallow
					scl_out <= !glitch_in;
					@(posedge clk_link_in);
					scl_out <= 1'b1;
					half();
				end
				scl_out <= 1'b0;
				sda_out <= 1'b0;
				half();
				done_out <= 1'b1;
			end
			else if (!go_in && done_out)
			begin
				scl_out <= 1'b1;
				half();
				sda_out <= 1'b1;
				half();
				done_out <= 1'b0;
			end
		end
	end
endmodule

// ---- hw/i2cc_channel_setup.sv ----
// I2C side of the control channel: register file, forwarding decision and SCL timing
// Operation
// - Default: forward only remote deserializer/slave IDs
// - Forward-all: forward every ID except local
// - Port select steers forward-all to port one
// - SDA sampling delayed by hold, 40 ns
// - Reject SCL/SDA pulses up to depth*5 ns
// - Master SCL high lasts high field plus five
// - Master SCL low lasts low field plus five
// - Slave drives SDA low-count before releasing SCL
// - High and low fields reset to 0x7F
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
module i2cc_channel_setup
	import i2cc_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [9:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic clk_link_in,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic slave_stretch_in,
	input wire logic slave_data_valid_in,
	input wire logic slave_sda_bit_in,
	output logic slave_release_out,
	output logic fwd_port0_out,
	output logic fwd_port1_out,
	output logic [6:0] target_id_out
);
	typedef enum logic [1:0] {I2CC_IDLE, I2CC_LOW, I2CC_HIGH, I2CC_SETUP} i2cc_scl_e;

	// ----------------------------------------
	// APB slave, system clock
	// ----------------------------------------
	logic [1:0] fwd_all;
	logic [6:0] setup_low7;
	logic [7:0] high_time;
	logic [7:0] low_time;
	logic port_sel;
	logic master_en;
	logic [6:0] local_id;
	logic [6:0] deser_id;
	logic [6:0] rslave_id;
	logic [1:0] fwd_s1;
	logic [1:0] fwd_s2;
	logic [7:0] idx;
	logic wr_en;
	logic hit_setup, hit_high, hit_low, hit_ctrl, hit_ids, hit_stat, hit_any;
	logic [31:0] rd_mux;

	// Word decode; low address bits beyond word alignment are ignored
	assign idx = paddr_in[9:2];
	assign hit_setup = idx == I2CC_IDX_SETUP;
	assign hit_high = idx == I2CC_IDX_HIGH;
	assign hit_low = idx == I2CC_IDX_LOW;
	assign hit_ctrl = idx == I2CC_IDX_CTRL;
	assign hit_ids = idx == I2CC_IDX_IDS;
	assign hit_stat = idx == I2CC_IDX_STATUS;
	assign hit_any = hit_setup | hit_high | hit_low | hit_ctrl | hit_ids | hit_stat;
	assign wr_en = psel_in && penable_in && pwrite_in;
	assign pready_out = 1'b1; // Zero wait states
	assign pslverr_out = psel_in && penable_in && !hit_any;

	// Read mux; the setup word shows forward-all of the selected port
	assign rd_mux = hit_setup ? {24'h000000, fwd_all[port_sel], setup_low7} :
		hit_high ? {24'h000000, high_time} :
		hit_low ? {24'h000000, low_time} :
		hit_ctrl ? {30'h00000000, master_en, port_sel} :
		hit_ids ? {9'h000, rslave_id, 1'b0, deser_id, 1'b0, local_id} :
		hit_stat ? {30'h00000000, fwd_s2} : 32'h00000000;

	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			prdata_out <= 32'h00000000;
		else if (psel_in && !penable_in && !pwrite_in)
			prdata_out <= rd_mux;
	end

	// Register writes
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			fwd_all <= {2{I2CC_SETUP_RST[I2CC_FWD_ALL_BIT]}};
			setup_low7 <= I2CC_SETUP_RST[6:0];
			high_time <= I2CC_HIGH_RST;
			low_time <= I2CC_LOW_RST;
			port_sel <= 1'b0;
			master_en <= 1'b0;
			local_id <= I2CC_LOCAL_ID_RST;
			deser_id <= I2CC_DESER_ID_RST;
			rslave_id <= I2CC_RSLAVE_ID_RST;
		end
		else if (wr_en)
		begin
			if (hit_setup)
			begin
				fwd_all[port_sel] <= pwdata_in[I2CC_FWD_ALL_BIT];
				setup_low7 <= pwdata_in[6:0];
			end
			if (hit_high)
				high_time <= pwdata_in[7:0];
			if (hit_low)
				low_time <= pwdata_in[7:0];
			if (hit_ctrl)
			begin
				port_sel <= pwdata_in[0];
				master_en <= pwdata_in[1];
			end
			if (hit_ids)
			begin
				local_id <= pwdata_in[6:0];
				deser_id <= pwdata_in[14:8];
				rslave_id <= pwdata_in[22:16];
			end
		end
	end

	// ----------------------------------------
	// Configuration handshake to the link domain
	// ----------------------------------------
	logic [I2CC_CFG_W-1:0] cfg_live;
	logic [I2CC_CFG_W-1:0] cfg_shadow;
	logic [I2CC_CFG_W-1:0] cfg_link;
	logic req_tgl, ack_s1, ack_s2;
	logic req_s1, req_s2, req_s3, ack_tgl;
	logic hs_idle;

	assign cfg_live = {fwd_all, setup_low7, high_time, low_time, master_en,
		local_id, deser_id, rslave_id};
	// Constant word, so both reset branches load constants only
	localparam logic [I2CC_CFG_W-1:0] cfg_reset = {{2{I2CC_SETUP_RST[I2CC_FWD_ALL_BIT]}},
		I2CC_SETUP_RST[6:0],
		I2CC_HIGH_RST, I2CC_LOW_RST, 1'b0, I2CC_LOCAL_ID_RST, I2CC_DESER_ID_RST,
		I2CC_RSLAVE_ID_RST};
	assign hs_idle = req_tgl == ack_s2;

	// Shadow only reloads when the last word was taken, so it is stable while sampled
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cfg_shadow <= cfg_reset;
			req_tgl <= 1'b0;
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end
		else
		begin
			ack_s1 <= ack_tgl;
			ack_s2 <= ack_s1;
			if (hs_idle && cfg_live != cfg_shadow)
			begin
				cfg_shadow <= cfg_live;
				req_tgl <= !req_tgl;
			end
		end
	end

	always_ff @(posedge clk_link_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
			ack_tgl <= 1'b0;
			cfg_link <= cfg_reset;
		end
		else
		begin
			req_s1 <= req_tgl;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
			ack_tgl <= req_s2;
			if (req_s2 != req_s3)
				cfg_link <= cfg_shadow;
		end
	end

	// Link-side field views
	logic [1:0] l_fwd_all;
	logic [2:0] l_hold;
	logic [3:0] l_depth;
	logic [8:0] tgt_high;
	logic [8:0] tgt_low;
	logic l_master;
	logic [6:0] l_local, l_deser, l_rslave;
	logic [2:0] filt_cyc;
	assign l_fwd_all = cfg_link[46:45];
	assign l_hold = cfg_link[44:42];
	assign l_depth = cfg_link[41:38];
	assign tgt_high = {1'b0, cfg_link[37:30]} + 9'(I2CC_SCL_EXTRA_CYC);
	assign tgt_low = {1'b0, cfg_link[29:22]} + 9'(I2CC_SCL_EXTRA_CYC);
	assign l_master = cfg_link[21];
	assign l_local = cfg_link[20:14];
	assign l_deser = cfg_link[13:7];
	assign l_rslave = cfg_link[6:0];
	// Depth steps to nearest oscillator cycles
	assign filt_cyc = 3'((32'(l_depth) * I2CC_FILT_STEP_NS + I2CC_OSC_PERIOD_NS / 2)
		/ I2CC_OSC_PERIOD_NS);

	// ----------------------------------------
	// Input filtering and SDA hold delay
	// ----------------------------------------
	logic scl_s, sda_s, scl_f, sda_f;
	i2cc_glitch_filter #(.CNT_W(3)) u_scl_filt (
		.clk_link_in(clk_link_in), .rst_n_in(rst_n_in), .raw_in(scl_in),
		.width_in(filt_cyc), .sync_out(scl_s), .filt_out(scl_f));
	i2cc_glitch_filter #(.CNT_W(3)) u_sda_filt (
		.clk_link_in(clk_link_in), .rst_n_in(rst_n_in), .raw_in(sda_in),
		.width_in(filt_cyc), .sync_out(sda_s), .filt_out(sda_f));

	logic [I2CC_HOLD_TAPS-1:0] sda_line;
	logic sda_held;
	// Tap 0 is undelayed; each hold step adds its cycles
	assign sda_line[0] = sda_f;
	assign sda_held = sda_line[32'(l_hold) * I2CC_HOLD_STEP_CYC];
	always_ff @(posedge clk_link_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			sda_line[I2CC_HOLD_TAPS-1:1] <= '1;
		else
			sda_line[I2CC_HOLD_TAPS-1:1] <= sda_line[I2CC_HOLD_TAPS-2:0];
	end

	// ----------------------------------------
	// Target ID capture and forwarding decision
	// ----------------------------------------
	logic scl_p, sda_p, start_c, stop_c, scl_rise;
	logic [7:0] shreg;
	logic [3:0] bit_cnt;
	logic addr_done;
	logic [6:0] addr;
	logic match_remote;
	logic [1:0] fwd_dec;
	logic [1:0] fwd_q;

	assign start_c = scl_f && sda_p && !sda_held;
	assign stop_c = scl_f && !sda_p && sda_held;
	assign scl_rise = scl_f && !scl_p;
	assign addr_done = scl_rise && bit_cnt == 4'd7;
	assign addr = shreg[6:0]; // First seven bits of the byte are the ID
	assign match_remote = addr == l_deser || addr == l_rslave;
	// Each port decides with its own forward-all bit
	assign fwd_dec[0] = l_fwd_all[0] ? addr != l_local : match_remote;
	assign fwd_dec[1] = l_fwd_all[1] ? addr != l_local : match_remote;

	always_ff @(posedge clk_link_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
			shreg <= 8'h00;
			bit_cnt <= 4'hF;
			fwd_q <= 2'b00;
			target_id_out <= 7'h00;
		end
		else
		begin
			scl_p <= scl_f;
			sda_p <= sda_held;
			if (start_c)
				bit_cnt <= 4'h0;
			else if (scl_rise && bit_cnt < 4'd8)
			begin
				shreg <= {shreg[6:0], sda_held};
				bit_cnt <= bit_cnt + 4'h1;
			end
			if (stop_c || start_c)
				fwd_q <= 2'b00;
			else if (addr_done)
			begin
				fwd_q <= fwd_dec;
				target_id_out <= addr;
			end
		end
	end
	assign fwd_port0_out = fwd_q[0];
	assign fwd_port1_out = fwd_q[1];

	// Forward flags back to the status word
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			fwd_s1 <= 2'b00;
			fwd_s2 <= 2'b00;
		end
		else
		begin
			fwd_s1 <= fwd_q;
			fwd_s2 <= fwd_s1;
		end
	end

	// ----------------------------------------
	// SCL timing: master phases and slave setup
	// ----------------------------------------
	i2cc_scl_e state, next_state;
	logic [8:0] cnt;
	logic [8:0] phase_tgt;
	logic phase_end;

	assign phase_tgt = (state == I2CC_HIGH) ? tgt_high : tgt_low;
	assign phase_end = cnt == phase_tgt - 9'd1;

	// Slave setup has priority; a master may only start from idle
	always_comb
	begin
		next_state = state;
		unique case (state)
			I2CC_IDLE:
				if (slave_stretch_in && slave_data_valid_in)
					next_state = I2CC_SETUP;
				else if (l_master)
					next_state = I2CC_LOW;
			I2CC_LOW:
				if (phase_end)
					next_state = I2CC_HIGH;
			I2CC_HIGH:
				if (phase_end)
					next_state = l_master ? I2CC_LOW : I2CC_IDLE;
			I2CC_SETUP:
				if (phase_end)
					next_state = I2CC_IDLE;
		endcase
	end

	always_ff @(posedge clk_link_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state <= I2CC_IDLE;
			cnt <= 9'h000;
			sda_out <= 1'b1;
		end
		else
		begin
			state <= next_state;
			cnt <= (next_state != state) ? 9'h000 : cnt + 9'h001;
			if (state == I2CC_IDLE && next_state == I2CC_SETUP)
				sda_out <= slave_sda_bit_in;
		end
	end

	// Open drain: SCL pulled low in low phase, setup and while stretching in idle
	assign scl_out = 1'b0;
	assign scl_oe_out = state == I2CC_LOW || state == I2CC_SETUP ||
		(state == I2CC_IDLE && slave_stretch_in);
	assign sda_oe_out = state == I2CC_SETUP;
	assign slave_release_out = state == I2CC_SETUP && phase_end;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_fwd_match_only: assert property (@(posedge clk_link_in) disable iff (!rst_n_in)
		addr_done && !start_c && !stop_c && !l_fwd_all[0] |=> fwd_q[0] ==
		($past(addr) == $past(l_deser) || $past(addr) == $past(l_rslave)))
		else $error("port 0 forwarded without an ID match");
	a_fwd_all_nonlocal: assert property (@(posedge clk_link_in) disable iff (!rst_n_in)
		addr_done && !start_c && !stop_c && l_fwd_all[0] |=> fwd_q[0] ==
		($past(addr) != $past(l_local)))
		else $error("forward-all decision wrong");
	a_port_sel_keep: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		wr_en && hit_setup && port_sel |=> fwd_all[0] == $past(fwd_all[0]) &&
		fwd_all[1] == $past(pwdata_in[I2CC_FWD_ALL_BIT]))
		else $error("port select did not steer forward-all");
	a_sda_hold_one: assert property (@(posedge clk_link_in) disable iff (!rst_n_in)
		l_hold == 3'd1 && $stable(l_hold) |-> sda_held == $past(sda_f, I2CC_HOLD_STEP_CYC))
		else $error("SDA hold delay wrong");
	a_filter_stable: assert property (@(posedge clk_link_in) disable iff (!rst_n_in)
		$changed(scl_f) && filt_cyc != 3'd0 |-> $past(scl_s) == scl_f &&
		$past(scl_s, 2) == scl_f)
		else $error("SCL filter passed a short pulse");
	a_high_length: assert property (@(posedge clk_link_in) disable iff (!rst_n_in)
		state == I2CC_HIGH && next_state != I2CC_HIGH |-> cnt == tgt_high - 9'd1)
		else $error("SCL high phase length wrong");
	a_low_length: assert property (@(posedge clk_link_in) disable iff (!rst_n_in)
		state == I2CC_LOW && next_state != I2CC_LOW |-> cnt == tgt_low - 9'd1 && scl_oe_out)
		else $error("SCL low phase length wrong");
	a_slave_setup: assert property (@(posedge clk_link_in) disable iff (!rst_n_in)
		slave_release_out |-> sda_oe_out && scl_oe_out && cnt == tgt_low - 9'd1 ##1
		!sda_oe_out)
		else $error("slave released SCL before setup time");
	a_reset_times: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!$past(rst_n_in) |-> high_time == 8'h7F && low_time == 8'h7F)
		else $error("SCL time fields not at reset value");
	c_forwarded: cover property (@(posedge clk_link_in) disable iff (!rst_n_in) $rose(fwd_q[0]));
	c_master_cycle: cover property (@(posedge clk_link_in) disable iff (!rst_n_in)
		state == I2CC_HIGH ##1 state == I2CC_LOW);
	c_slave_release: cover property (@(posedge clk_link_in) disable iff (!rst_n_in)
		slave_release_out);
endmodule

// ---- hw/i2cc_glitch_filter.sv ----
// Synchroniser and glitch filter for one I2C input line
`timescale 1ns/1ns
module i2cc_glitch_filter
	import i2cc_pkg::*;
#(
	parameter int CNT_W = 3
)
(
	input wire logic clk_link_in,
	input wire logic rst_n_in,
	input wire logic raw_in,
	input wire logic [CNT_W-1:0] width_in,
	output logic sync_out,
	output logic filt_out
);
	logic meta;
	logic sync;
	logic [CNT_W-1:0] cnt;
	logic differs;
	logic accept;

	// ----------------------------------------
	// Two-stage synchroniser
	// ----------------------------------------
	always_ff @(posedge clk_link_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			meta <= 1'b1;
			sync <= 1'b1;
		end
		else
		begin
			meta <= raw_in;
			sync <= meta;
		end
	end

	// A new level is taken only once it outlasts the width
	assign differs = sync != filt_out;
	assign accept = differs && (cnt >= width_in);
	assign sync_out = sync;

	always_ff @(posedge clk_link_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cnt <= '0;
			filt_out <= 1'b1;
		end
		else
		begin
			cnt <= (differs && !accept) ? cnt + 1'b1 : '0;
			if (accept)
				filt_out <= sync;
		end
	end
endmodule

// ---- hw/i2cc_pkg.sv ----
// Package with offsets, reset values and timing constants of the I2C channel setup block
package i2cc_pkg;
	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [7:0] I2CC_IDX_SETUP = 8'h17;
	localparam logic [7:0] I2CC_IDX_HIGH = 8'h18;
	localparam logic [7:0] I2CC_IDX_LOW = 8'h19;
	localparam logic [7:0] I2CC_IDX_CTRL = 8'h20;
	localparam logic [7:0] I2CC_IDX_IDS = 8'h21;
	localparam logic [7:0] I2CC_IDX_STATUS = 8'h22;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int I2CC_FWD_ALL_BIT = 7;
	localparam int I2CC_HOLD_LSB = 4;
	localparam int I2CC_DEPTH_LSB = 0;
	localparam logic [7:0] I2CC_SETUP_RST = 8'h1E;
	localparam logic [7:0] I2CC_HIGH_RST = 8'h7F;
	localparam logic [7:0] I2CC_LOW_RST = 8'h7F;
	localparam logic [6:0] I2CC_LOCAL_ID_RST = 7'h0C;
	localparam logic [6:0] I2CC_DESER_ID_RST = 7'h2C;
	localparam logic [6:0] I2CC_RSLAVE_ID_RST = 7'h50;
	// ----------------------------------------
	// Timing on the oscillator clock
	// ----------------------------------------
	localparam int I2CC_OSC_PERIOD_NS = 40;
	localparam int I2CC_HOLD_STEP_NS = 40;
	localparam int I2CC_FILT_STEP_NS = 5;
	localparam int I2CC_SCL_EXTRA_CYC = 5;
	// Nearest whole cycles per hold step
	localparam int I2CC_HOLD_STEP_CYC =
		(I2CC_HOLD_STEP_NS + I2CC_OSC_PERIOD_NS / 2) / I2CC_OSC_PERIOD_NS;
	localparam int I2CC_HOLD_TAPS = 7 * I2CC_HOLD_STEP_CYC + 1;
	localparam int I2CC_CFG_W = 47;
endpackage
